// ===== fes_pkg.sv
/*
 * Package for the flash erase, status and reset controller: pin carriers,
 * command codes, state codes and every timing count, all derived from the
 * 100 MHz system clock.
 * Assumes one clock domain and a word-wide parallel flash on the far side.
 */
package fes_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock, widths and field positions.
    localparam int CLK_NS = 10;
    localparam int CNT_W = 21;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int SECTOR_SELECT_LOW_BIT = 12;
    localparam int SECTOR_SELECT_HIGH_BIT = 17;
    localparam int POLL_STATUS_BIT = 7;
    localparam int TOGGLE_STATUS_BIT = 6;

    ////////////////////////////////////////////////////////////////////////
    // Times in their own unit, as printed.
    localparam int US = 1000;
    localparam int RESET_PULSE_NS = 500;
    localparam int RESET_HIGH_NS = 50;
    localparam int RESET_ABORT_RECOVERY_NS = 20 * US;
    localparam int RESET_IDLE_RECOVERY_NS = 500;
    localparam int BUSY_DELAY_NS = 90;
    localparam int UNPROTECT_RESET_SETUP_NS = 4 * US;
    localparam int PULSE_MIN_NS = 100;
    localparam int PROTECT_PULSE_WIDTH_NS = 10 * US;
    localparam int UNPROTECT_PULSE_WIDTH_NS = 12 * US * US;
    localparam int WE_LOW_NS = 35;
    localparam int WE_HIGH_NS = 30;
    localparam int ACCESS_NS = 90;
    localparam int SYNC_STAGES = 2;

    // Least times round up, longest times round down, never below one cycle.
    function automatic int cyc_up(input int ns);
        return (ns + CLK_NS - 1) / CLK_NS;
    endfunction

    function automatic int cyc_dn(input int ns);
        return (ns / CLK_NS < 1) ? 1 : ns / CLK_NS;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Cycle counts; each _END is the last counter value of its phase.
    localparam int RP_CYC = cyc_up(RESET_PULSE_NS);
    localparam int RH_CYC = cyc_up(RESET_HIGH_NS);
    localparam int READY1_CYC = cyc_dn(RESET_ABORT_RECOVERY_NS);
    localparam int READY2_CYC = cyc_dn(RESET_IDLE_RECOVERY_NS);
    localparam int BUSY_CYC = cyc_up(BUSY_DELAY_NS);
    localparam int RSP_CYC = cyc_up(UNPROTECT_RESET_SETUP_NS);
    localparam int PULSE_MIN_CYC = cyc_up(PULSE_MIN_NS);
    localparam int PROT_CYC = cyc_up(PROTECT_PULSE_WIDTH_NS);
    localparam int UNPROT_CYC = cyc_up(UNPROTECT_PULSE_WIDTH_NS);
    localparam int IDLE_WAIT_CYC = (READY2_CYC - RP_CYC > RH_CYC) ? READY2_CYC - RP_CYC : RH_CYC;
    localparam logic [CNT_W-1:0] RP_END = CNT_W'(RP_CYC - 1);
    localparam logic [CNT_W-1:0] ABORT_WAIT_END = CNT_W'(READY1_CYC - RP_CYC - 1);
    localparam logic [CNT_W-1:0] IDLE_WAIT_END = CNT_W'(IDLE_WAIT_CYC - 1);
    localparam logic [CNT_W-1:0] BUSY_END = CNT_W'(BUSY_CYC - 1);
    localparam logic [CNT_W-1:0] RSP_END = CNT_W'(RSP_CYC - 1);
    localparam logic [CNT_W-1:0] WP_END = CNT_W'(cyc_up(WE_LOW_NS) - 1);
    localparam logic [CNT_W-1:0] WPH_END = CNT_W'(cyc_up(WE_HIGH_NS) - 1);
    localparam logic [CNT_W-1:0] RD_END = CNT_W'(cyc_up(ACCESS_NS) + SYNC_STAGES - 1);

    ////////////////////////////////////////////////////////////////////////
    // Command sequence addresses and data for a word-wide sector erase.
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_A = 18'h0_0555;
    localparam logic [ADDR_W-1:0] UNLOCK_ADDR_B = 18'h0_02AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_A = 16'h00AA;
    localparam logic [DATA_W-1:0] UNLOCK_DATA_B = 16'h0055;
    localparam logic [DATA_W-1:0] ERASE_SETUP_DATA = 16'h0080;
    localparam logic [DATA_W-1:0] SECTOR_ERASE_DATA = 16'h0030;
    localparam logic [2:0] ERASE_LAST_STEP = 3'h5;
    localparam logic [2:0] ERASE_POLL_STEP = 3'h6;

    ////////////////////////////////////////////////////////////////////////
    // Enumerations and carriers.
    typedef enum logic [2:0] {
        OP_READ = 3'b000,
        OP_WRITE = 3'b001,
        OP_ERASE = 3'b010,
        OP_RESET = 3'b011,
        OP_PROTECT = 3'b100,
        OP_UNPROTECT = 3'b101
    } fes_op_t;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_SETUP = 4'b0001,
        ST_WE_LO = 4'b0010,
        ST_WE_HI = 4'b0011,
        ST_OE_LO = 4'b0100,
        ST_BUSY = 4'b0101,
        ST_RST_LO = 4'b0110,
        ST_RST_HI = 4'b0111,
        ST_HV_SETUP = 4'b1000
    } fes_st_t;

    typedef struct packed {
        logic [2:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } fes_cmd_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dq_o;
        logic dq_oe;
        logic ce_b;
        logic oe_b;
        logic we_b;
        logic reset_b;
        logic reset_hv;
        logic a9_oe_hv;
    } fes_pins_t;

    localparam fes_pins_t PINS_IDLE = '{ce_b: 1'b1, oe_b: 1'b1, we_b: 1'b1, reset_b: 1'b1, default: '0};

endpackage

// ===== fes_ctrl.sv
/*
 * Host controller that drives a parallel flash through its pins: single
 * reads and writes, a full sector erase with status polling, hardware reset
 * with abort, temporary unprotect and high-voltage protect pulses.
 * Assumes the flash pins are wired by the surroundings from the pin struct
 * and that the user holds a command stable while cmd_valid is high.
 */
// What this block does
// RULE1: The sector to erase is chosen by address bits 12 to 17 sent with the last erase write.
// RULE2: The flash verifies its own erase, so the controller runs no verify pass.
// RULE3: While erasing the poll status bit reads 0 and it reads 1 once the erase is over.
// RULE4: The toggle status bit flips on every status read while an algorithm runs.
// RULE5: The toggle bit is valid at any address, the poll bit only inside the target sector.
// RULE6: A reset during an algorithm aborts it and the flash is ready within 20 us.
// RULE7: A reset with no algorithm running leaves the flash ready within 500 ns.
// RULE8: The reset pin is held low for at least 500 ns to abort an algorithm.
// RULE9: After reset rises it stays high at least 50 ns before a read starts.
// RULE10: Reset sits at the high voltage level at least 4 us before any write in temporary unprotect.
// RULE11: A protect write pulse under high voltage is at least 100 ns, typically 10 us.
// RULE12: An unprotect write pulse under high voltage is at least 100 ns, typically 12 ms.
// RULE13: The flash shows busy no later than 90 ns after a program or erase starts.
// RULE14: After the erase the flash is back in array read mode.
`timescale 1ns/1ns
`default_nettype none

module fes_ctrl
    import fes_pkg::*;
#(
    parameter logic [CNT_W-1:0] PROT_PULSE_END = CNT_W'(PROT_CYC - 1),
    parameter logic [CNT_W-1:0] UNPROT_PULSE_END = CNT_W'(UNPROT_CYC - 1)
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Command port
    input wire logic cmd_valid,
    output logic cmd_ready,
    input wire fes_cmd_t cmd,
    input wire logic abort_req,
    input wire logic temp_unprotect_req,
    // Answer port
    output logic resp_valid,
    output logic [DATA_W-1:0] resp_data,
    output logic alg_running,
    output logic dev_busy,
    // Flash pins
    output fes_pins_t flash_pins,
    input wire logic [DATA_W-1:0] flash_dq_i,
    input wire logic ready_busy_output
);

    typedef struct packed {
        fes_st_t st;
        logic [2:0] op;
        logic [2:0] seq;
        logic [CNT_W-1:0] cnt;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic in_alg;
        logic first;
        logic prev_tog;
        logic resp_valid;
        logic [DATA_W-1:0] resp_data;
        fes_pins_t pins;
        logic [DATA_W-1:0] dq_m;
        logic [DATA_W-1:0] dq_s;
        logic rb_m;
        logic rb_s;
    } fes_state_t;

    localparam fes_state_t STATE_INIT = '{st: ST_IDLE, pins: PINS_IDLE, rb_m: 1'b1, rb_s: 1'b1, default: '0};

    fes_state_t s_r;
    fes_state_t s_nxt;
    logic poll_end;
    logic erase_done;

    ////////////////////////////////////////////////////////////////////////
    // Address and data of each write in the sector erase command sequence.
    function automatic logic [ADDR_W+DATA_W-1:0] erase_step(input logic [2:0] idx, input logic [ADDR_W-1:0] sec);
        unique case (idx)
            3'h0: return {UNLOCK_ADDR_A, UNLOCK_DATA_A};
            3'h1: return {UNLOCK_ADDR_B, UNLOCK_DATA_B};
            3'h2: return {UNLOCK_ADDR_A, ERASE_SETUP_DATA};
            3'h3: return {UNLOCK_ADDR_A, UNLOCK_DATA_A};
            3'h4: return {UNLOCK_ADDR_B, UNLOCK_DATA_B};
            default: return {sec, SECTOR_ERASE_DATA}; // RULE1
        endcase
    endfunction

    // Commands are taken only in idle and only once the reset pin level matches the request.
    assign cmd_ready = (s_r.st == ST_IDLE) && (temp_unprotect_req == s_r.pins.reset_hv);
    assign resp_valid = s_r.resp_valid;
    assign resp_data = s_r.resp_data;
    assign alg_running = s_r.in_alg;
    assign dev_busy = ~s_r.rb_s;
    assign flash_pins = s_r.pins;

    // End of a status read during erase polling, and whether the erase is over.
    assign poll_end = (s_r.st == ST_OE_LO) && (s_r.cnt == RD_END) && (s_r.op == OP_ERASE);
    assign erase_done = s_r.dq_s[POLL_STATUS_BIT] || (!s_r.first && s_r.dq_s[TOGGLE_STATUS_BIT] == s_r.prev_tog);

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic of the whole controller.
    always_comb begin
        s_nxt = s_r;
        s_nxt.resp_valid = 1'b0;
        s_nxt.dq_m = flash_dq_i;
        s_nxt.dq_s = s_r.dq_m;
        s_nxt.rb_m = ready_busy_output;
        s_nxt.rb_s = s_r.rb_m;
        s_nxt.cnt = s_r.cnt + CNT_W'(1);
        unique case (s_r.st)
            ST_IDLE: begin
                s_nxt.cnt = '0;
                if (temp_unprotect_req && !s_r.pins.reset_hv) begin
                    s_nxt.pins.reset_hv = 1'b1;
                    s_nxt.st = ST_HV_SETUP;
                end else if (!temp_unprotect_req && s_r.pins.reset_hv) begin
                    s_nxt.pins.reset_hv = 1'b0;
                end else if (cmd_valid) begin
                    s_nxt.op = cmd.op;
                    s_nxt.addr = cmd.addr;
                    s_nxt.wdata = cmd.wdata;
                    s_nxt.seq = '0;
                    s_nxt.first = 1'b1;
                    if (cmd.op == OP_ERASE) begin
                        s_nxt.addr = {cmd.addr[SECTOR_SELECT_HIGH_BIT:SECTOR_SELECT_LOW_BIT],
                            SECTOR_SELECT_LOW_BIT'(0)}; // RULE1
                    end
                    if (cmd.op == OP_RESET) begin
                        s_nxt.pins.reset_b = 1'b0;
                        s_nxt.pins.reset_hv = 1'b0;
                        s_nxt.st = ST_RST_LO;
                    end else if (cmd.op <= OP_UNPROTECT) begin
                        s_nxt.st = ST_SETUP;
                    end else begin
                        s_nxt.resp_valid = 1'b1;
                    end
                end
            end
            ST_HV_SETUP: begin
                if (s_r.cnt == RSP_END) begin // RULE10
                    s_nxt.st = ST_IDLE;
                end
            end
            ST_SETUP: begin
                s_nxt.cnt = '0;
                s_nxt.pins.ce_b = 1'b0;
                if (s_r.op == OP_READ || (s_r.op == OP_ERASE && s_r.seq == ERASE_POLL_STEP)) begin
                    // Status reads stay on the sector address so the poll bit is valid too.
                    s_nxt.pins.addr = s_r.addr; // RULE5
                    s_nxt.pins.oe_b = 1'b0;
                    s_nxt.st = ST_OE_LO;
                end else begin
                    if (s_r.op == OP_ERASE) begin
                        {s_nxt.pins.addr, s_nxt.pins.dq_o} = erase_step(s_r.seq, s_r.addr);
                    end else begin
                        {s_nxt.pins.addr, s_nxt.pins.dq_o} = {s_r.addr, s_r.wdata};
                    end
                    s_nxt.pins.dq_oe = 1'b1;
                    s_nxt.pins.a9_oe_hv = (s_r.op == OP_PROTECT) || (s_r.op == OP_UNPROTECT);
                    s_nxt.pins.we_b = 1'b0;
                    s_nxt.st = ST_WE_LO;
                end
            end
            ST_WE_LO: begin
                if ((s_r.op == OP_PROTECT && s_r.cnt == PROT_PULSE_END) // RULE11
                        || (s_r.op == OP_UNPROTECT && s_r.cnt == UNPROT_PULSE_END) // RULE12
                        || (s_r.op != OP_PROTECT && s_r.op != OP_UNPROTECT && s_r.cnt == WP_END)) begin
                    s_nxt.cnt = '0;
                    s_nxt.pins.we_b = 1'b1;
                    s_nxt.st = ST_WE_HI;
                end
            end
            ST_WE_HI: begin
                if (s_r.cnt == WPH_END) begin
                    s_nxt.cnt = '0;
                    s_nxt.pins.ce_b = 1'b1;
                    s_nxt.pins.dq_oe = 1'b0;
                    s_nxt.pins.a9_oe_hv = 1'b0;
                    if (s_r.op == OP_ERASE && s_r.seq != ERASE_LAST_STEP) begin
                        s_nxt.seq = s_r.seq + 3'h1;
                        s_nxt.st = ST_SETUP;
                    end else if (s_r.op == OP_ERASE) begin
                        s_nxt.seq = ERASE_POLL_STEP;
                        s_nxt.in_alg = 1'b1;
                        s_nxt.st = ST_BUSY;
                    end else begin
                        s_nxt.resp_valid = 1'b1;
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_BUSY: begin
                // No status read until the flash has had time to show busy.
                if (s_r.cnt == BUSY_END) begin // RULE13
                    s_nxt.st = ST_SETUP;
                end
            end
            ST_OE_LO: begin
                if (s_r.cnt == RD_END) begin
                    s_nxt.pins.oe_b = 1'b1;
                    s_nxt.resp_data = s_r.dq_s;
                    if (s_r.op == OP_ERASE && !erase_done) begin // RULE3 RULE4
                        s_nxt.first = 1'b0;
                        s_nxt.prev_tog = s_r.dq_s[TOGGLE_STATUS_BIT];
                        s_nxt.st = ST_SETUP;
                    end else begin
                        // The flash verified itself and is back in array mode.
                        s_nxt.in_alg = 1'b0; // RULE2 RULE14
                        s_nxt.pins.ce_b = 1'b1;
                        s_nxt.resp_valid = 1'b1;
                        s_nxt.st = ST_IDLE;
                    end
                end
            end
            ST_RST_LO: begin
                if (s_r.cnt == RP_END) begin // RULE8
                    s_nxt.cnt = '0;
                    s_nxt.pins.reset_b = 1'b1;
                    s_nxt.st = ST_RST_HI;
                end
            end
            ST_RST_HI: begin
                // Wait out the recovery time that fits what was running at reset.
                if (s_r.cnt == (s_r.in_alg ? ABORT_WAIT_END : IDLE_WAIT_END)) begin // RULE6 RULE7 RULE9
                    s_nxt.in_alg = 1'b0;
                    s_nxt.resp_valid = 1'b1;
                    s_nxt.st = ST_IDLE;
                end
            end
            default: begin
                s_nxt.pins = PINS_IDLE;
                s_nxt.st = ST_IDLE;
            end
        endcase
        // An abort during erase polling takes the reset path at once.
        if (abort_req && s_r.in_alg && s_r.st != ST_RST_LO && s_r.st != ST_RST_HI) begin
            s_nxt.pins = PINS_IDLE;
            s_nxt.pins.reset_b = 1'b0; // RULE6
            s_nxt.cnt = '0;
            s_nxt.resp_valid = 1'b0;
            s_nxt.st = ST_RST_LO;
        end
    end

    // State register.
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            s_r <= STATE_INIT;
        end else begin
            s_r <= s_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Helper counters watched only by the checks below.
    localparam int A_CW = 24;
    logic [A_CW-1:0] a_lo_cnt;
    logic [A_CW-1:0] a_since_fall;
    logic [A_CW-1:0] a_since_rise;
    logic [A_CW-1:0] a_hv_cnt;
    logic [A_CW-1:0] a_we_cnt;
    logic a_aborted;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            a_lo_cnt <= '0;
            a_since_fall <= '1;
            a_since_rise <= '1;
            a_hv_cnt <= '0;
            a_we_cnt <= '0;
            a_aborted <= 1'b0;
        end else begin
            a_lo_cnt <= s_r.pins.reset_b ? '0 : a_lo_cnt + A_CW'(1);
            a_since_fall <= (!s_r.pins.reset_b && a_lo_cnt == '0) ? A_CW'(1) :
                (&a_since_fall ? a_since_fall : a_since_fall + A_CW'(1));
            a_since_rise <= !s_r.pins.reset_b ? '0 : (&a_since_rise ? a_since_rise : a_since_rise + A_CW'(1));
            a_hv_cnt <= s_r.pins.reset_hv ? a_hv_cnt + A_CW'(1) : '0;
            a_we_cnt <= s_r.pins.we_b ? '0 : a_we_cnt + A_CW'(1);
            if (!s_r.pins.reset_b && a_lo_cnt == '0) begin
                a_aborted <= s_r.in_alg;
            end
        end
    end

    default clocking a_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    sequence s_rst_release;
        $rose(s_r.pins.reset_b);
    endsequence

    sequence s_erase_started;
        $rose(s_r.in_alg);
    endsequence

    a_rst_low_width: assert property (s_rst_release |-> a_lo_cnt >= A_CW'(RP_CYC)) // RULE8
        else $error("reset pin released too early");
    a_read_after_rst: assert property ($fell(s_r.pins.oe_b) |-> a_since_rise >= A_CW'(RH_CYC)) // RULE9
        else $error("read started too soon after reset release");
    a_abort_recovery: assert property ($fell(s_r.pins.ce_b) && a_aborted |-> a_since_fall >= A_CW'(READY1_CYC)) // RULE6
        else $error("access too soon after aborting reset");
    a_idle_recovery: assert property ($fell(s_r.pins.ce_b) |-> a_since_fall >= A_CW'(READY2_CYC)) // RULE7
        else $error("access too soon after idle reset");
    a_hv_write_setup: assert property ($fell(s_r.pins.we_b) && s_r.pins.reset_hv |-> a_hv_cnt >= A_CW'(RSP_CYC)) // RULE10
        else $error("write too soon after high voltage on reset");
    a_protect_pulse: assert property ($rose(s_r.pins.we_b) && s_r.op == OP_PROTECT
        |-> $past(s_r.pins.a9_oe_hv) && a_we_cnt == A_CW'(PROT_PULSE_END) + A_CW'(1)
            && a_we_cnt >= A_CW'(PULSE_MIN_CYC)) // RULE11
        else $error("protect pulse width wrong");
    a_unprot_pulse: assert property ($rose(s_r.pins.we_b) && s_r.op == OP_UNPROTECT
        |-> a_we_cnt == A_CW'(UNPROT_PULSE_END) + A_CW'(1) && a_we_cnt >= A_CW'(PULSE_MIN_CYC)) // RULE12
        else $error("unprotect pulse width wrong");
    a_busy_gap: assert property (s_erase_started |-> s_r.pins.oe_b [*8]) // RULE13
        else $error("status read before busy delay");
    a_sector_addr: assert property ($fell(s_r.pins.we_b) && s_r.op == OP_ERASE && s_r.seq == ERASE_LAST_STEP
        |-> s_r.pins.addr[SECTOR_SELECT_LOW_BIT-1:0] == '0 && s_r.pins.dq_o == SECTOR_ERASE_DATA) // RULE1
        else $error("erase confirm write has wrong sector address");
    a_poll_done: assert property (poll_end && s_r.dq_s[POLL_STATUS_BIT] && !abort_req
        |=> resp_valid && !alg_running ##1 !resp_valid) // RULE3 RULE14
        else $error("poll bit set but erase not finished");
    a_toggle_done: assert property (poll_end && !s_r.first && s_r.dq_s[TOGGLE_STATUS_BIT] == s_r.prev_tog
        && !abort_req |=> resp_valid) // RULE4
        else $error("toggle stopped but erase not finished");

endmodule

`default_nettype wire

// ===== fes_flash_model.sv
/*
 * Behavioural model of the parallel flash: sector erase by command sequence,
 * status bits while erasing, array data otherwise, and reset abort.
 * Assumes the controller's registered pins and one 100 MHz clock for timing.
 */
`timescale 1ns/1ns
`default_nettype none

module fes_flash_model
    import fes_pkg::*;
#(
    parameter int ERASE_CYC = 300
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Flash pins
    input wire fes_pins_t flash_pins,
    output logic [DATA_W-1:0] flash_dq_i,
    output logic ready_busy_output,
    // Observations for the bench
    output logic [7:0] viol,
    output logic [15:0] last_pulse
);
    localparam logic [DATA_W-1:0] SEQ [6] = '{UNLOCK_DATA_A, UNLOCK_DATA_B, ERASE_SETUP_DATA,
        UNLOCK_DATA_A, UNLOCK_DATA_B, SECTOR_ERASE_DATA};
    fes_pins_t p;
    logic erasing_r, erased_r, tog_r, oe_q, we_q, abrt_r;
    logic [5:0] sec_r, pend_r;
    logic [DATA_W-1:0] last_r, rd;
    int step, left, low_cnt, hi_cnt, hv_cnt, wl_cnt;

    assign p = flash_pins;
    assign ready_busy_output = !erasing_r;

    ////////////////////////////////////////////////////////////////////////
    // Status while erasing, array data otherwise; a released bus shows a changing pattern.
    always_comb begin
        rd = p.addr[15:0] ^ 16'hA5C3;
        if (erasing_r) begin
            rd = '0;
            rd[TOGGLE_STATUS_BIT] = tog_r;
        end else if (erased_r && p.addr[17:12] == sec_r) begin
            rd = 16'hFFFF;
        end
        flash_dq_i = (!p.ce_b && !p.oe_b) ? rd : ~last_r;
    end

    ////////////////////////////////////////////////////////////////////////
    // Command decode, erase timing, reset abort and checks on the host's pin timing.
    always @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            {erasing_r, erased_r, tog_r, abrt_r, viol, last_pulse, last_r} <= '0;
            {oe_q, we_q} <= 2'b11;
            {step, left, low_cnt, hv_cnt, wl_cnt} <= '0;
            hi_cnt <= 100;
        end else begin
            last_r <= flash_dq_i;
            oe_q <= p.oe_b;
            we_q <= p.we_b;
            low_cnt <= p.reset_b ? 0 : low_cnt + 1;
            hi_cnt <= p.reset_b ? hi_cnt + 1 : 0;
            hv_cnt <= p.reset_hv ? hv_cnt + 1 : 0;
            wl_cnt <= (!p.we_b && p.a9_oe_hv) ? wl_cnt + 1 : 0;
            if (!p.reset_b && erasing_r) abrt_r <= 1'b1;
            if (p.reset_b && low_cnt > 0) begin
                abrt_r <= 1'b0;
                if (abrt_r && low_cnt < RP_CYC) viol <= viol + 1;
            end
            if (!p.oe_b && oe_q && !p.ce_b) begin
                tog_r <= ~tog_r;
                if (hi_cnt < RH_CYC) viol <= viol + 1;
            end
            if (!p.we_b && we_q && p.reset_hv && hv_cnt < RSP_CYC) viol <= viol + 1;
            if (p.we_b && !we_q && p.a9_oe_hv) begin
                last_pulse <= 16'(wl_cnt);
                if (wl_cnt < PULSE_MIN_CYC) viol <= viol + 1;
            end
            if (p.we_b && !we_q && !p.ce_b && !erasing_r) begin
                step <= (p.dq_o == SEQ[step] && step < 5) ? step + 1 : 0;
                if (step == 5 && p.dq_o == SECTOR_ERASE_DATA) begin
                    erasing_r <= 1'b1;
                    left <= ERASE_CYC;
                    pend_r <= p.addr[17:12];
                end
            end
            if (erasing_r) begin
                left <= left - 1;
                if (left == 0) begin
                    {erasing_r, erased_r} <= 2'b01;
                    sec_r <= pend_r;
                end
            end
            if (!p.reset_b) begin
                erasing_r <= 1'b0;
                step <= 0;
            end
        end
    end
endmodule

`default_nettype wire

// ===== fes_ctrl_bench.sv
/*
 * Self-checking bench for the flash controller with the flash model behind it.
 * Assumes the design's assertions guard its own timing; this bench checks data and outcomes.
 */
`timescale 1ns/1ns
`default_nettype none

module fes_ctrl_bench;
    import fes_pkg::*;

    typedef struct packed {
        logic [2:0] op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic chk;
        logic [DATA_W-1:0] exp;
    } fes_row_t;

    logic clk_sys = 1'b0;
    logic rst_b, cmd_valid, cmd_ready, abort_req, temp_unprotect_req, resp_valid;
    logic alg_running, dev_busy, ready_busy_output;
    fes_cmd_t cmd;
    fes_pins_t flash_pins;
    logic [DATA_W-1:0] resp_data, flash_dq_i;
    logic [7:0] viol;
    logic [15:0] last_pulse;
    int errors = 0;
    int cmp_count = 0;
    fes_row_t rows [8] = '{
        '{OP_ERASE, 18'h2_3456, 16'h0000, 1'b1, 16'hFFFF},
        '{OP_READ, 18'h2_3000, 16'h0000, 1'b1, 16'hFFFF},
        '{OP_READ, 18'h2_3FFF, 16'h0000, 1'b1, 16'hFFFF},
        '{OP_READ, 18'h2_4000, 16'h0000, 1'b1, 16'hE5C3},
        '{OP_READ, 18'h2_2FFF, 16'h0000, 1'b1, 16'h8A3C},
        '{OP_WRITE, 18'h0_0100, 16'h1234, 1'b0, 16'h0000},
        '{3'h6, 18'h0_0000, 16'h0000, 1'b0, 16'h0000},
        '{3'h7, 18'h0_0000, 16'h0000, 1'b0, 16'h0000}};

    fes_ctrl #(.PROT_PULSE_END(21'h00_000F), .UNPROT_PULSE_END(21'h00_0014)) u_fes_ctrl (
        .clk_sys(clk_sys), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
        .abort_req(abort_req), .temp_unprotect_req(temp_unprotect_req), .resp_valid(resp_valid),
        .resp_data(resp_data), .alg_running(alg_running), .dev_busy(dev_busy), .flash_pins(flash_pins),
        .flash_dq_i(flash_dq_i), .ready_busy_output(ready_busy_output));

    fes_flash_model u_fes_flash_model (.clk_sys(clk_sys), .rst_b(rst_b), .flash_pins(flash_pins),
        .flash_dq_i(flash_dq_i), .ready_busy_output(ready_busy_output), .viol(viol), .last_pulse(last_pulse));

    ////////////////////////////////////////////////////////////////////////
    // Clock at 100 MHz.
    always #5 clk_sys = ~clk_sys;

    // Compares one value and reports a difference at once.
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("errors=%0d comparisons=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Offers one command after an edge and waits, bounded, for its answer.
    task automatic do_cmd(input logic [2:0] op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        int n;
        n = 0;
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b1;
        cmd = '{op: op, addr: a, wdata: d};
        while (cmd_ready !== 1'b1 && n < 3000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        @(posedge clk_sys);
        #1;
        cmd_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 6000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        if (n >= 6000) errors++;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watchdog well beyond the expected run of some three thousand cycles.
    initial begin
        #400000;
        errors++;
        close_out();
    end

    // Reset, the table of ordinary cases, then abort, reset, unprotect and pulse cases.
    initial begin
        {rst_b, cmd_valid, abort_req, temp_unprotect_req} = '0;
        cmd = '0;
        repeat (16) @(posedge clk_sys);
        check({flash_pins, resp_valid, alg_running, dev_busy}, {PINS_IDLE, 3'b000});
        #1;
        rst_b = 1'b1;
        foreach (rows[i]) begin
            do_cmd(rows[i].op, rows[i].addr, rows[i].wdata);
            if (rows[i].chk) check(resp_data, rows[i].exp);
        end
        fork
            do_cmd(OP_ERASE, 18'h1_0000, 16'h0000);
            begin
                repeat (120) @(posedge clk_sys);
                #1;
                check(dev_busy, 1'b1);
                abort_req = 1'b1;
            end
        join
        abort_req = 1'b0;
        check({alg_running, ready_busy_output}, 2'b01);
        do_cmd(OP_READ, 18'h1_0000, 16'h0000);
        check(resp_data, 16'hA5C3);
        do_cmd(OP_RESET, 18'h0_0000, 16'h0000);
        do_cmd(OP_READ, 18'h2_2FFF, 16'h0000);
        check(resp_data, 16'h8A3C);
        temp_unprotect_req = 1'b1;
        @(posedge clk_sys);
        #1;
        check(cmd_ready, 1'b0);
        do_cmd(OP_WRITE, 18'h0_0200, 16'h1234);
        check(flash_pins.reset_hv, 1'b1);
        temp_unprotect_req = 1'b0;
        do_cmd(OP_PROTECT, 18'h0_5000, 16'h0000);
        check(last_pulse, 16'h0010);
        do_cmd(OP_UNPROTECT, 18'h0_5000, 16'h0000);
        check(last_pulse, 16'h0015);
        check(viol, 8'h00);
        close_out();
    end
endmodule

`default_nettype wire
